//--- dv/asq_sample_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin chkGot = (got); nTests++; if (chkGot !== (exp)) begin \
    failures++; $display("MISMATCH %s expected %0h seen %0h", name, exp, chkGot); end end
module asq_sample_sequencer_test;
    import asq_pkg::*;
    logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, samplingWindow, convRun;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, hwTrigger, refSel;
    logic [11:0] convResult;
    logic [15:0] pinConnect;
    logic [3:0] chanSel, lowSt, highSt;
    int failures = 0;
    int nTests = 0;
    logic [31:0] chkGot;
    int seed = 32'h96e3;
    int cycles = 0;
    int winCnt = 0;
    int runCnt = 0;
    int qWin[$], qRun[$];
    logic [15:0] qPin[$];
    logic [11:0] qRes[$];
    logic [3:0] qChan[$];
    logic [2:0] qRef[$];
    logic [3:0] chanM[16];
    logic [2:0] refM[16];
    logic eosM[16];
    logic [11:0] resM[16];
    logic [15:0] flagM = 16'h0;

    asq_sample_sequencer u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .hwTrigger(hwTrigger),
        .convResult(convResult), .samplingWindow(samplingWindow), .pinConnect(pinConnect),
        .convRun(convRun), .chanSel(chanSel), .refSel(refSel));
    assign hready = hreadyout;

    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    // The analog core result changes every cycle so a stale capture shows up.
    always @(posedge clk)
    begin
        convResult <= 12'($random(seed));
        cycles++;
        if (cycles > 60000)
        begin
            failures++;
            test_done();
        end
    end

    // Records every window and conversion seen at the pins.
    always @(posedge clk)
    begin
        if (rst_n)
        begin
            if (!samplingWindow)
                `CHK("pinsIdle", 16'h0, pinConnect)
            if (samplingWindow && winCnt == 1)
                qPin.push_back(pinConnect);
            if (samplingWindow)
                winCnt++;
            else if (winCnt != 0)
            begin
                qWin.push_back(winCnt);
                winCnt = 0;
            end
            if (convRun && runCnt == 12)
            begin
                qRes.push_back(convResult);
                qChan.push_back(chanSel);
                qRef.push_back(refSel);
            end
            if (convRun)
                runCnt++;
            else if (runCnt != 0)
            begin
                qRun.push_back(runCnt);
                runCnt = 0;
            end
        end
    end

    task automatic busWrite(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= 1'b1;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwrite <= 1'b0; hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
    endtask : busWrite

    task automatic busRead(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= 1'b0;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00;
        do @(posedge clk); while (hready !== 1'b1);
        d = hrdata;
    endtask : busRead

    function automatic logic [31:0] mkCtrl(input logic [1:0] mode, input logic [3:0] st,
                                           input logic [1:0] src, input logic [4:0] f);
        return {8'h0, highSt, lowSt, 3'h0, st, src, mode, f};
    endfunction : mkCtrl

    function automatic int pulseWin(input int slot);
        return ASQ_SAMPLE_UNIT * ((slot >= 8 ? int'(highSt) : int'(lowSt)) + 1);
    endfunction : pulseWin

    task automatic checkConv(input int slot, input int expWin);
        int k;
        for (k = 0; k < 3000 && qRun.size() == 0; k++)
            @(posedge clk);
        if (qRun.size() == 0)
        begin
            `CHK("convSeen", 1'b1, 1'b0)
            return;
        end
        `CHK("winLen", expWin, qWin.pop_front())
        `CHK("runLen", 13, qRun.pop_front())
        `CHK("chan", chanM[slot], qChan.pop_front())
        `CHK("ref", refM[slot], qRef.pop_front())
        `CHK("pin", 16'h1 << chanM[slot], qPin.pop_front())
        resM[slot] = qRes.pop_front();
        flagM[slot] = 1'b1;
    endtask : checkConv

    task automatic expectQuiet(input int n);
        repeat (n) @(posedge clk);
        `CHK("noConv", 0, qRun.size())
    endtask : expectQuiet

    task automatic checkMem(input string tname);
        busRead({24'h0, ASQ_OFF_FLAGS}, rd);
        `CHK("flags", flagM, rd[15:0])
        for (int i = 0; i < 16; i++)
            if (flagM[i])
            begin
                busRead({24'h0, ASQ_REG_RES, 4'(i), 2'b00}, rd);
                `CHK("result", resM[i], rd[11:0])
            end
        busWrite({24'h0, ASQ_OFF_FLAGS}, {16'h0, flagM});
        busRead({24'h0, ASQ_OFF_FLAGS}, rd);
        `CHK("flagsClr", 16'h0, rd[15:0])
        flagM = 16'h0;
        $display("test %s done, %0d mismatches so far", tname, failures);
    endtask : checkMem

    task automatic pulseHw(input int len);
        @(posedge clk);
        hwTrigger[1] <= 1'b0;
        repeat (len) @(posedge clk);
        hwTrigger[1] <= 1'b1;
    endtask : pulseHw

    task test_done;
        $display("checks %0d, mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    initial
    begin
        rst_n = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
        hwTrigger = 3'b111; convResult = 0;
        lowSt = 4'($random(seed));
        highSt = 4'($random(seed));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, read-only status and an unmapped word.
        busRead({24'h0, ASQ_OFF_CTRL}, rd);
        `CHK("ctrlRst", ASQ_CTRL_RST, rd)
        busWrite({24'h0, ASQ_OFF_STAT}, 32'hffffffff);
        busRead({24'h0, ASQ_OFF_STAT}, rd);
        `CHK("statRst", 32'h0, rd)
        busWrite(32'h3c, 32'hffffffff);
        busRead(32'h3c, rd);
        `CHK("unmapped", 32'h0, rd)
        for (int i = 0; i < 16; i++)
        begin
            chanM[i] = 4'($random(seed));
            refM[i] = 3'($random(seed));
            eosM[i] = (i == 1);
            busWrite({24'h0, ASQ_REG_SLOT, 4'(i), 2'b00}, {24'h0, eosM[i], refM[i], chanM[i]});
            busRead({24'h0, ASQ_REG_SLOT, 4'(i), 2'b00}, rd);
            `CHK("slotRb", {24'h0, eosM[i], refM[i], chanM[i]}, rd)
        end
        $display("test registers done, %0d mismatches so far", failures);
        // Single conversion, software start twice without toggling, then a low-bank slot.
        busWrite(0, mkCtrl(2'b00, 4'd9, 2'd0, 5'b00101));
        busWrite(0, mkCtrl(2'b00, 4'd9, 2'd0, 5'b00111));
        checkConv(9, pulseWin(9));
        busWrite(0, mkCtrl(2'b00, 4'd9, 2'd0, 5'b00111));
        checkConv(9, pulseWin(9));
        busWrite(0, mkCtrl(2'b00, 4'd3, 2'd0, 5'b00100));
        busWrite(0, mkCtrl(2'b00, 4'd3, 2'd0, 5'b00111));
        checkConv(3, pulseWin(3));
        expectQuiet(100);
        checkMem("single");
        // Back-to-back sequence from slot 14 wrapping through 15 to the end flag at slot 1.
        busWrite(0, mkCtrl(2'b01, 4'd14, 2'd0, 5'b01100));
        busWrite(0, mkCtrl(2'b01, 4'd14, 2'd0, 5'b01111));
        for (int s = 14; ; s = (s + 1) % 16)
        begin
            checkConv(s, pulseWin(s));
            if (eosM[s])
                break;
        end
        expectQuiet(150);
        checkMem("sequence");
        // Repeat sequence, one software trigger per entry, restarting at the start slot.
        busWrite(0, mkCtrl(2'b11, 4'd15, 2'd0, 5'b00100));
        foreach (chanM[k])
            if (k < 4)
            begin
                busWrite(0, mkCtrl(2'b11, 4'd15, 2'd0, 5'b00111));
                checkConv(k % 3 == 0 ? 15 : k - 1, pulseWin(k % 3 == 0 ? 15 : k - 1));
            end
        checkMem("repeatSeq");
        // Repeat single with back-to-back; clearing enable stops it.
        busWrite(0, mkCtrl(2'b10, 4'd12, 2'd0, 5'b01100));
        busWrite(0, mkCtrl(2'b10, 4'd12, 2'd0, 5'b01111));
        repeat (3) checkConv(12, pulseWin(12));
        busWrite(0, mkCtrl(2'b10, 4'd12, 2'd0, 5'b01100));
        repeat (300) @(posedge clk);
        while (qRun.size() > 0)
            checkConv(12, pulseWin(12));
        busRead({24'h0, ASQ_OFF_STAT}, rd);
        `CHK("idle", 1'b0, rd[ASQ_T_BUSY])
        expectQuiet(150);
        checkMem("repeatSingle");
        // Extended sampling from an inverted hardware trigger, with the enable-toggle lock.
        busWrite(0, mkCtrl(2'b00, 4'd6, 2'd2, 5'b10000));
        pulseHw(9);
        expectQuiet(80);
        busWrite(0, mkCtrl(2'b00, 4'd6, 2'd2, 5'b10001));
        pulseHw(20);
        checkConv(6, 20);
        busRead({24'h0, ASQ_OFF_STAT}, rd);
        `CHK("lock", 1'b1, rd[ASQ_T_LOCK])
        pulseHw(9);
        expectQuiet(80);
        busWrite(0, mkCtrl(2'b00, 4'd6, 2'd2, 5'b10000));
        busWrite(0, mkCtrl(2'b00, 4'd6, 2'd2, 5'b10001));
        pulseHw(7);
        checkConv(6, 7);
        checkMem("extended");
        test_done();
    end
endmodule : asq_sample_sequencer_test
`default_nettype wire

//--- include/asq_pkg.sv
package asq_pkg;
    localparam int ASQ_SLOTS = 16;
    localparam int ASQ_IDX_W = 4;
    localparam int ASQ_RES_W = 12;
    localparam int ASQ_TMR_W = 7;
    localparam int ASQ_SAMPLE_UNIT = 4;
    localparam logic [3:0] ASQ_CONV_LAST = 4'hc;
    localparam logic [7:0] ASQ_OFF_CTRL = 8'h00;
    localparam logic [7:0] ASQ_OFF_STAT = 8'h04;
    localparam logic [7:0] ASQ_OFF_FLAGS = 8'h08;
    localparam logic [1:0] ASQ_REG_SLOT = 2'h1;
    localparam logic [1:0] ASQ_REG_RES = 2'h2;
    localparam int ASQ_C_EN = 0;
    localparam int ASQ_C_SW = 1;
    localparam int ASQ_C_PULSE = 2;
    localparam int ASQ_C_B2B = 3;
    localparam int ASQ_C_INV = 4;
    localparam int ASQ_C_MODE = 5;
    localparam int ASQ_C_SRC = 7;
    localparam int ASQ_C_START = 9;
    localparam int ASQ_C_LOWST = 16;
    localparam int ASQ_C_HIGHST = 20;
    localparam logic [31:0] ASQ_CTRL_RST = 32'h0;
    localparam logic [31:0] ASQ_CTRL_MASK = 32'h00ff1ffd;
    localparam int ASQ_S_CHAN = 0;
    localparam int ASQ_S_REF = 4;
    localparam int ASQ_S_EOS = 7;
    localparam logic [1:0] ASQ_MODE_SINGLE = 2'h0;
    localparam logic [1:0] ASQ_SRC_SW = 2'h0;
    localparam int ASQ_T_BUSY = 0;
    localparam int ASQ_T_WIN = 1;
    localparam int ASQ_T_LOCK = 2;
    localparam int ASQ_T_PTR = 4;
    typedef enum logic [2:0] {
        ASQ_IDLE = 3'b001,
        ASQ_SAMPLE = 3'b010,
        ASQ_CONVERT = 3'b100
    } asq_state_t;
endpackage : asq_pkg

//--- include/asq_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface asq_tmr_if;
    logic start;
    logic [asq_pkg::ASQ_TMR_W-1:0] cycles;
    logic window;
    logic done;
    modport ctl (output start, output cycles, input window, input done);
    modport tmr (input start, input cycles, output window, output done);
endinterface : asq_tmr_if
`default_nettype wire

//--- logic/asq_sample_sequencer.sv
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module asq_sample_sequencer #(
    parameter int HW_TRIGS = 3,
    parameter int CHANNELS = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [HW_TRIGS-1:0] hwTrigger,
    input wire logic [asq_pkg::ASQ_RES_W-1:0] convResult,
    output logic samplingWindow,
    output logic [CHANNELS-1:0] pinConnect,
    output logic convRun,
    output logic [3:0] chanSel,
    output logic [2:0] refSel
);
    import asq_pkg::*;

    initial
    begin
        if (HW_TRIGS < 1 || HW_TRIGS > 3) $error("HW_TRIGS must be 1 to 3.");
        if (CHANNELS < 1 || CHANNELS > 16) $error("CHANNELS must be 1 to 16.");
    end

    function automatic logic [ASQ_TMR_W-1:0] intervalFor(input logic [3:0] idx,
        input logic [3:0] lowSt, input logic [3:0] highSt);
        logic [3:0] f;
        f = idx[3] ? highSt : lowSt;
        return ASQ_TMR_W'(ASQ_SAMPLE_UNIT * (int'(f) + 1));
    endfunction : intervalFor

    asq_tmr_if tmr ();
    asq_sample_timer u_tmr (
        .clk(clk),
        .rst_n(rst_n),
        .t(tmr)
    );

    logic [HW_TRIGS-1:0] hwSync;
    asq_sync #(.W(HW_TRIGS)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(hwTrigger),
        .q(hwSync)
    );

    logic [31:0] ctrl;
    logic swStart;
    logic [7:0] slotCtl [ASQ_SLOTS];
    logic [ASQ_RES_W-1:0] results [ASQ_SLOTS];
    logic [ASQ_SLOTS-1:0] flags;
    asq_state_t state, next_state;
    logic [ASQ_IDX_W-1:0] ptr, next_ptr;
    logic [3:0] convCnt;
    logic inSeq;
    logic needToggle;
    logic trigPrev;
    logic wrPend;
    logic [7:0] wrAddr;

    wire enable = ctrl[ASQ_C_EN];
    wire pulseSel = ctrl[ASQ_C_PULSE];
    wire b2b = ctrl[ASQ_C_B2B];
    wire [1:0] mode = ctrl[ASQ_C_MODE +: 2];
    wire [1:0] src = ctrl[ASQ_C_SRC +: 2];
    wire [3:0] startIdx = ctrl[ASQ_C_START +: 4];
    wire [3:0] lowSt = ctrl[ASQ_C_LOWST +: 4];
    wire [3:0] highSt = ctrl[ASQ_C_HIGHST +: 4];
    wire seqMode = mode[0];
    wire repeatMode = mode[1];
    wire b2bOn = b2b && (mode != ASQ_MODE_SINGLE) && pulseSel;

    wire [3:0] trigVec = 4'({hwSync, swStart});
    wire trigLevel = trigVec[src] ^ ctrl[ASQ_C_INV];
    wire trigRise = trigLevel && !trigPrev;

    wire [7:0] curSlot = slotCtl[ptr];
    wire curEos = curSlot[ASQ_S_EOS];
    wire [7:0] nextSlot = slotCtl[next_ptr];
    wire [3:0] nextChan = nextSlot[ASQ_S_CHAN +: 4];
    wire [CHANNELS-1:0] nextPins = CHANNELS'(1) << nextChan;

    wire startGo = (state == ASQ_IDLE) && enable && !needToggle && trigRise;
    wire convDone = (state == ASQ_CONVERT) && (convCnt == ASQ_CONV_LAST);
    wire lastInSeq = !seqMode || curEos;
    wire autoNext = b2bOn && (!lastInSeq || (repeatMode && enable));
    wire sampleEnd = pulseSel ? tmr.done : !trigLevel;

    always_comb
    begin
        next_state = state;
        next_ptr = ptr;
        case (state)
            ASQ_IDLE:
            begin
                if (startGo)
                begin
                    next_state = ASQ_SAMPLE;
                    next_ptr = inSeq ? ptr : startIdx;
                end
            end
            ASQ_SAMPLE:
            begin
                if (sampleEnd)
                    next_state = ASQ_CONVERT;
            end
            ASQ_CONVERT:
            begin
                if (convDone)
                begin
                    next_state = autoNext ? ASQ_SAMPLE : ASQ_IDLE;
                    if (seqMode && !curEos)
                        next_ptr = ptr + 1'b1;
                    else if (seqMode)
                        next_ptr = startIdx;
                end
            end
            default:
                next_state = ASQ_IDLE;
        endcase
    end

    assign tmr.start = pulseSel && (next_state == ASQ_SAMPLE) && (state != ASQ_SAMPLE);
    assign tmr.cycles = intervalFor(next_ptr, lowSt, highSt);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= ASQ_IDLE;
            ptr <= '0;
            convCnt <= '0;
            trigPrev <= 1'b0;
        end
        else
        begin
            state <= next_state;
            ptr <= next_ptr;
            convCnt <= (state == ASQ_CONVERT) ? convCnt + 1'b1 : '0;
            trigPrev <= trigLevel;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            inSeq <= 1'b0;
            needToggle <= 1'b0;
        end
        else if (convDone)
        begin
            inSeq <= seqMode && !curEos;
            needToggle <= needToggle || (lastInSeq && !repeatMode && src != ASQ_SRC_SW);
        end
        else if (!enable)
        begin
            needToggle <= 1'b0;
            inSeq <= (state != ASQ_IDLE) && inSeq;
        end
    end

    // The pins follow the window in the same flop stage, so no pin sees a glitch.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            samplingWindow <= 1'b0;
            pinConnect <= '0;
            convRun <= 1'b0;
            chanSel <= '0;
            refSel <= '0;
        end
        else
        begin
            samplingWindow <= next_state == ASQ_SAMPLE;
            pinConnect <= (next_state == ASQ_SAMPLE) ? nextPins : '0;
            convRun <= next_state == ASQ_CONVERT;
            chanSel <= nextChan;
            refSel <= nextSlot[ASQ_S_REF +: 3];
        end
    end

    // Bus side. Zero wait states; read data is sampled in the address phase.
    wire addrPhase = hsel && htrans[1] && hready;
    wire [7:0] rdAddr = haddr[7:0];
    wire [3:0] rdIdx = rdAddr[5:2];
    wire [3:0] wrIdx = wrAddr[5:2];
    wire wrCtrl = wrPend && (wrAddr == ASQ_OFF_CTRL);
    wire wrFlags = wrPend && (wrAddr == ASQ_OFF_FLAGS);
    wire wrSlot = wrPend && (wrAddr[7:6] == ASQ_REG_SLOT) && (wrAddr[1:0] == 2'h0);
    wire [31:0] statWord = 32'({ptr, 1'b0, needToggle, samplingWindow, state != ASQ_IDLE})
        << ASQ_T_BUSY;
    wire [ASQ_SLOTS-1:0] flagSet = convDone ? (ASQ_SLOTS'(1) << ptr) : '0;
    wire [ASQ_SLOTS-1:0] flagClr = wrFlags ? hwdata[ASQ_SLOTS-1:0] : '0;
    wire [31:0] rdWord =
        (rdAddr == ASQ_OFF_CTRL) ? {ctrl[31:2], swStart, ctrl[0]} :
        (rdAddr == ASQ_OFF_STAT) ? statWord :
        (rdAddr == ASQ_OFF_FLAGS) ? 32'(flags) :
        (rdAddr[7:6] == ASQ_REG_SLOT && rdAddr[1:0] == 2'h0) ? 32'(slotCtl[rdIdx]) :
        (rdAddr[7:6] == ASQ_REG_RES && rdAddr[1:0] == 2'h0) ? 32'(results[rdIdx]) :
        32'h0;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wrPend <= 1'b0;
            wrAddr <= '0;
            hrdata <= '0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            wrPend <= addrPhase && hwrite;
            wrAddr <= rdAddr;
            hrdata <= (addrPhase && !hwrite) ? rdWord : 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl <= ASQ_CTRL_RST;
            swStart <= 1'b0;
            flags <= '0;
        end
        else
        begin
            if (wrCtrl)
                ctrl <= hwdata & ASQ_CTRL_MASK;
            // Software may set the start bit while hardware retires it; the set wins.
            if (wrCtrl)
                swStart <= hwdata[ASQ_C_SW];
            else if (pulseSel && state == ASQ_SAMPLE && sampleEnd)
                swStart <= 1'b0;
            flags <= (flags & ~flagClr) | flagSet;
        end
    end

    always_ff @(posedge clk)
    begin
        if (wrSlot)
            slotCtl[wrIdx] <= hwdata[7:0];
        if (convDone)
            results[ptr] <= convResult;
    end

    // Checks below watch this block's state and outputs, plus the timer window and convResult.
    logic [ASQ_TMR_W:0] winLen;
    logic [4:0] runLen;
    always_ff @(posedge clk)
    begin
        runLen <= convRun ? runLen + 1'b1 : '0;
        if (!rst_n)
            winLen <= '0;
        else
            winLen <= samplingWindow ? winLen + 1'b1 : '0;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_pins_isolated;
        !samplingWindow |-> pinConnect == '0;
    endproperty
    a_pins_isolated: assert property (p_pins_isolated) else $error("Pin driven outside window.");

    property p_conv_len;
        (convRun |-> runLen <= 5'(ASQ_CONV_LAST)) and
            ($fell(convRun) |-> runLen == 5'(ASQ_CONV_LAST) + 5'h1);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("Conversion not 13 cycles.");

    property p_low_bank;
        $fell(samplingWindow) && pulseSel && !ptr[3]
            |-> winLen == (ASQ_TMR_W + 1)'(ASQ_SAMPLE_UNIT * (int'(lowSt) + 1));
    endproperty
    a_low_bank: assert property (p_low_bank) else $error("Low bank window length wrong.");

    property p_high_bank;
        $fell(samplingWindow) && pulseSel && ptr[3]
            |-> winLen == (ASQ_TMR_W + 1)'(ASQ_SAMPLE_UNIT * (int'(highSt) + 1));
    endproperty
    a_high_bank: assert property (p_high_bank) else $error("High bank window length wrong.");

    property p_flag_set;
        convDone |=> flags[$past(ptr)] && results[$past(ptr)] == $past(convResult);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Result flag not set.");

    property p_wrap;
        convDone && seqMode && ptr == 4'hf && !curEos |=> ptr == 4'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("Pointer did not wrap.");

    property p_single_ptr;
        convDone && !seqMode |=> ptr == $past(ptr);
    endproperty
    a_single_ptr: assert property (p_single_ptr) else $error("Single mode moved pointer.");

    property p_reload;
        startGo && !inSeq |=> ptr == $past(startIdx) ##1 samplingWindow;
    endproperty
    a_reload: assert property (p_reload) else $error("Start index not loaded.");

    property p_disabled;
        state == ASQ_IDLE && !enable |=> !samplingWindow && !convRun;
    endproperty
    a_disabled: assert property (p_disabled) else $error("Sampling while disabled.");

    property p_relock;
        convDone && !repeatMode && lastInSeq && src != ASQ_SRC_SW |=> needToggle;
    endproperty
    a_relock: assert property (p_relock) else $error("Enable toggle not demanded.");

    property p_b2b;
        convDone && autoNext |=> tmr.window && state == ASQ_SAMPLE;
    endproperty
    a_b2b: assert property (p_b2b) else $error("Back-to-back did not restart.");

    c_wrap: cover property (convDone && seqMode && ptr == 4'hf);
    c_b2b_repeat: cover property (convDone && autoNext && repeatMode);
    c_extended: cover property ($fell(samplingWindow) && !pulseSel);
endmodule : asq_sample_sequencer
`default_nettype wire

//--- logic/asq_sample_timer.sv
`timescale 1ns/1ps
`default_nettype none
module asq_sample_timer (
    input wire logic clk,
    input wire logic rst_n,
    asq_tmr_if.tmr t
);
    import asq_pkg::*;
    logic busy;
    logic [ASQ_TMR_W-1:0] cnt;
    logic [ASQ_TMR_W-1:0] last;
    assign t.window = busy;
    assign t.done = busy && (cnt == last);
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            busy <= 1'b0;
            cnt <= '0;
            last <= '0;
        end
        else if (t.start)
        begin
            busy <= 1'b1;
            cnt <= '0;
            last <= t.cycles - 1'b1;
        end
        else if (t.done)
            busy <= 1'b0;
        else if (busy)
            cnt <= cnt + 1'b1;
    end
endmodule : asq_sample_timer
`default_nettype wire

//--- logic/asq_sync.sv
`timescale 1ns/1ps
`default_nettype none
module asq_sync #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    initial
    begin
        if (W < 1) $error("asq_sync needs W of at least 1.");
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : asq_sync
`default_nettype wire
